// ### core/lfs_pkg.sv
// Purpose: constants shared by the lift fault supervisor
// Assumes: 200 MHz system clock
// Notes:   fault numbers and sub-codes as reported to software
package lfs_pkg;
    // *****************************
    // clock and timing
    // *****************************
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned FINAL_HOLD_MS  = 1500;  // 1,5 s persistence
    localparam int unsigned FINAL_HOLD_CYC = FINAL_HOLD_MS * 1000 * CLK_MHZ;
    localparam int unsigned LOCK_DLY_MS    = 3000;  // "a few seconds"
    localparam int unsigned LOCK_DLY_CYC   = LOCK_DLY_MS * 1000 * CLK_MHZ;
    localparam int unsigned OPEN_TMO_MS    = 8000;  // reset value of timeout
    localparam logic [1:0]  DOOR_RETRIES   = 2'h3;

    // *****************************
    // fault numbers and sub-codes
    // *****************************
    localparam logic [7:0] F_SAFE_STOP   = 8'h07;
    localparam logic [7:0] F_DOOR_LOCK   = 8'h09;
    localparam logic [7:0] F_DOOR_A      = 8'h0a;
    localparam logic [7:0] F_DOOR_B      = 8'h0b;
    localparam logic [7:0] F_SAFE_TRAVEL = 8'h0c;
    localparam logic [7:0] F_THERMAL     = 8'h0d;
    localparam logic [7:0] F_PARAM_MEM   = 8'h0e;
    localparam logic [7:0] F_FINAL_LIM   = 8'h0f;
    localparam logic [7:0] F_FIRE        = 8'h10;
    localparam logic [7:0] SUB_NONE      = 8'h00;
    localparam logic [7:0] SUB_LANDING   = 8'h05;
    localparam logic [7:0] SUB_CARDOOR   = 8'h06;
    localparam logic [7:0] SUB_TH_ONE    = 8'h01;
    localparam logic [7:0] SUB_TH_TWO    = 8'h02;
    localparam logic [7:0] SUB_TH_BOTH   = 8'h03;
    localparam logic [7:0] SUB_TH_DOOR   = 8'h0a;

    // *****************************
    // register map (byte addresses)
    // *****************************
    localparam logic [7:0] A_STATUS   = 8'h00;  // sticky events, w1c
    localparam logic [7:0] A_MASK     = 8'h04;
    localparam logic [7:0] A_LAST     = 8'h08;  // [15:8] sub, [7:0] number
    localparam logic [7:0] A_CTRL     = 8'h0c;  // operator reset, config
    localparam logic [7:0] A_OPEN_TMO = 8'h10;  // door opening time, cycles
    localparam logic [7:0] A_LIVE     = 8'h14;  // live conditions

    // ctrl bits
    localparam int C_RESET_FINAL = 0;           // write 1: clear fault 15
    localparam int C_AUTO_DOOR   = 1;
    localparam int C_HAS_LIM_A   = 2;
    localparam int C_HAS_LIM_B   = 3;
    localparam int C_HAS_FIRE    = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_001e;

    // status bit positions, one per fault
    localparam int NEV   = 9;
    localparam int E_7   = 0;
    localparam int E_9   = 1;
    localparam int E_10  = 2;
    localparam int E_11  = 3;
    localparam int E_12  = 4;
    localparam int E_13  = 5;
    localparam int E_14  = 6;
    localparam int E_15  = 7;
    localparam int E_16  = 8;

    typedef enum logic [2:0] {
        LFS_D_IDLE  = 3'b000,
        LFS_D_OPEN  = 3'b001,
        LFS_D_CLOSE = 3'b010,
        LFS_D_WAIT  = 3'b011,
        LFS_D_DONE  = 3'b100
    } lfs_lock_t;
endpackage

// ### core/lfs_supervisor.sv
// Purpose: fault supervision of a lift controller, faults 7 to 16
// Assumes: all field inputs already debounced and synchronous to CLK_I
// Notes:   contacts are given as "closed" levels, high = contact closed
// Summary of operation
// - chain open at first tap with car stopped raises 7, clears all calls, lamp off.
// - door lock tap open while a call is registered raises 9.
// - fault 9 carries sub-code 5 for landing locks and 6 for car door.
// - automatic door reopens and recloses up to 3 times, then all calls drop.
// - other doors drop all calls after a fixed delay of some seconds.
// - door A with open limit raises 10 if not fully open in the set time.
// - after an opening timeout that door is treated as open.
// - door B is supervised the same way with its own signals, fault 11.
// - chain open ahead of first tap while travelling raises 12, stops, clears car calls.
// - open motor thermal contacts raise 13 with sub-code 1, 2 or 3.
// - active door operator thermal input on the car top board reports 13 sub 10.
// - faulty parameter store raises 14 as a stopping fault.
// - final limit chain opening held 1,5 s latches fault 15.
// - latched 15 holds after reclosing, blocks landing calls and motion till reset.
// - any active fire sensor, when fitted, raises 16.
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor #(
    parameter int unsigned FINAL_HOLD = lfs_pkg::FINAL_HOLD_CYC,
    parameter int unsigned LOCK_DELAY = lfs_pkg::LOCK_DLY_CYC,
    parameter int unsigned FIRE_N     = 4
) (
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    // register port
    input  wire logic [7:0]        ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [31:0]       RDATA_O,
    // field contacts and controller state
    input  wire logic              SAFETY_TAP_FIRST_I,
    input  wire logic              FINAL_LIMIT_TRIP_I,
    input  wire logic              LANDING_LOCKS_I,
    input  wire logic              CAR_DOOR_I,
    input  wire logic              CALL_PENDING_I,
    input  wire logic              CAR_RUNNING_I,
    input  wire logic              DOOR_A_OPEN_COMMAND_I,
    input  wire logic              DOOR_A_OPEN_LIMIT_I,
    input  wire logic              DOOR_B_OPEN_COMMAND_I,
    input  wire logic              DOOR_B_OPEN_LIMIT_I,
    input  wire logic              MOTOR_THERMAL_CONTACT_ONE_I,
    input  wire logic              MOTOR_THERMAL_CONTACT_TWO_I,
    input  wire logic              CAR_TOP_BOARD_THERMAL_I,
    input  wire logic              PARAM_MEM_FAULT_I,
    input  wire logic [FIRE_N-1:0] FIRE_SENSOR_I,
    // actions
    output logic                   CLEAR_ALL_CALLS_O,
    output logic                   CLEAR_CAR_CALLS_O,
    output logic                   BLOCK_LANDING_CALLS_O,
    output logic                   STOP_CAR_O,
    output logic                   SAFETY_LAMP_O,
    output logic                   DOOR_REOPEN_O,
    output logic                   DOOR_RECLOSE_O,
    output logic                   DOOR_A_OPEN_O,
    output logic                   DOOR_B_OPEN_O,
    output logic                   IRQ_O
);
    // *****************************
    // registers
    // *****************************
    logic [lfs_pkg::NEV-1:0] status;
    logic [lfs_pkg::NEV-1:0] mask;
    logic [31:0]             ctrl;
    logic [31:0]             open_tmo;
    logic [15:0]             last_fault;
    logic [lfs_pkg::NEV-1:0] cond_q;
    logic [31:0]             final_cnt;
    logic                    final_latched;
    logic [31:0]             lock_cnt;
    logic [1:0]              retry_cnt;
    lfs_pkg::lfs_lock_t      lock_st;
    logic [31:0]             tmo_a;
    logic [31:0]             tmo_b;
    logic                    slip_a;
    logic                    slip_b;

    // *****************************
    // condition decode
    // *****************************
    wire chain_open  = !SAFETY_TAP_FIRST_I;
    wire lock_open   = !(LANDING_LOCKS_I && CAR_DOOR_I);
    wire th1_open    = !MOTOR_THERMAL_CONTACT_ONE_I;
    wire th2_open    = !MOTOR_THERMAL_CONTACT_TWO_I;
    wire auto_door   = ctrl[lfs_pkg::C_AUTO_DOOR];
    wire fire_any    = ctrl[lfs_pkg::C_HAS_FIRE] && (|FIRE_SENSOR_I);
    wire final_hold  = final_cnt >= FINAL_HOLD - 1;
    wire tmo_a_hit   = ctrl[lfs_pkg::C_HAS_LIM_A] && DOOR_A_OPEN_COMMAND_I
                       && !DOOR_A_OPEN_LIMIT_I && tmo_a >= open_tmo;
    wire tmo_b_hit   = ctrl[lfs_pkg::C_HAS_LIM_B] && DOOR_B_OPEN_COMMAND_I
                       && !DOOR_B_OPEN_LIMIT_I && tmo_b >= open_tmo;

    // live conditions, one per fault; an event is a rising condition
    logic [lfs_pkg::NEV-1:0] cond;
    assign cond[lfs_pkg::E_7]  = chain_open && !CAR_RUNNING_I;
    assign cond[lfs_pkg::E_9]  = lock_open && CALL_PENDING_I;
    assign cond[lfs_pkg::E_10] = tmo_a_hit;
    assign cond[lfs_pkg::E_11] = tmo_b_hit;
    assign cond[lfs_pkg::E_12] = chain_open && CAR_RUNNING_I;
    assign cond[lfs_pkg::E_13] = th1_open || th2_open
                                 || CAR_TOP_BOARD_THERMAL_I;
    assign cond[lfs_pkg::E_14] = PARAM_MEM_FAULT_I;
    assign cond[lfs_pkg::E_15] = final_latched;
    assign cond[lfs_pkg::E_16] = fire_any;
    wire [lfs_pkg::NEV-1:0] rise = cond & ~cond_q;

    // sub-codes
    wire [7:0] sub_lock = !LANDING_LOCKS_I ? lfs_pkg::SUB_LANDING
                                           : lfs_pkg::SUB_CARDOOR;
    wire [7:0] sub_th   = (th1_open && th2_open) ? lfs_pkg::SUB_TH_BOTH :
                          th1_open ? lfs_pkg::SUB_TH_ONE :
                          th2_open ? lfs_pkg::SUB_TH_TWO :
                          lfs_pkg::SUB_TH_DOOR;

    // newest record: highest fault number rising this cycle wins
    logic [15:0] next_last;
    always_comb begin
        next_last = last_fault;
        if (rise[lfs_pkg::E_7])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_SAFE_STOP};
        if (rise[lfs_pkg::E_9])
            next_last = {sub_lock, lfs_pkg::F_DOOR_LOCK};
        if (rise[lfs_pkg::E_10])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_DOOR_A};
        if (rise[lfs_pkg::E_11])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_DOOR_B};
        if (rise[lfs_pkg::E_12])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_SAFE_TRAVEL};
        if (rise[lfs_pkg::E_13])
            next_last = {sub_th, lfs_pkg::F_THERMAL};
        if (rise[lfs_pkg::E_14])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_PARAM_MEM};
        if (rise[lfs_pkg::E_15])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_FINAL_LIM};
        if (rise[lfs_pkg::E_16])
            next_last = {lfs_pkg::SUB_NONE, lfs_pkg::F_FIRE};
    end

    // *****************************
    // register access decode
    // *****************************
    wire wr_status = WR_I && ADDR_I == lfs_pkg::A_STATUS;
    wire wr_mask   = WR_I && ADDR_I == lfs_pkg::A_MASK;
    wire wr_ctrl   = WR_I && ADDR_I == lfs_pkg::A_CTRL;
    wire wr_tmo    = WR_I && ADDR_I == lfs_pkg::A_OPEN_TMO;
    wire op_reset  = wr_ctrl && WDATA_I[lfs_pkg::C_RESET_FINAL];
    wire [31:0] live_word = {24'h0, slip_b, slip_a, final_latched,
                             lock_open, chain_open, cond[2:0]};
    wire [31:0] rd_mux =
        ADDR_I == lfs_pkg::A_STATUS   ? {23'h0, status} :
        ADDR_I == lfs_pkg::A_MASK     ? {23'h0, mask} :
        ADDR_I == lfs_pkg::A_LAST     ? {16'h0, last_fault} :
        ADDR_I == lfs_pkg::A_CTRL     ? {ctrl[31:1], 1'b0} :
        ADDR_I == lfs_pkg::A_OPEN_TMO ? open_tmo :
        ADDR_I == lfs_pkg::A_LIVE     ? live_word : 32'h0;
    wire [lfs_pkg::NEV-1:0] next_status =
        rise | (status & ~(wr_status ? WDATA_I[lfs_pkg::NEV-1:0]
                                     : {lfs_pkg::NEV{1'b0}}));

    // register file, set wins over write-one-clear
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            status     <= '0;
            mask       <= '0;
            ctrl       <= lfs_pkg::CTRL_RST;
            open_tmo   <= lfs_pkg::OPEN_TMO_MS * 1000 * lfs_pkg::CLK_MHZ;
            last_fault <= 16'h0;
            cond_q     <= '0;
            RDATA_O    <= 32'h0;
            IRQ_O      <= 1'b0;
        end else begin
            status     <= next_status;
            mask       <= wr_mask ? WDATA_I[lfs_pkg::NEV-1:0] : mask;
            ctrl       <= wr_ctrl ? {WDATA_I[31:1], 1'b0} : ctrl;
            open_tmo   <= wr_tmo ? WDATA_I : open_tmo;
            last_fault <= next_last;
            cond_q     <= cond;
            RDATA_O    <= RD_I ? rd_mux : 32'h0;
            IRQ_O      <= |(next_status & mask);
        end
    end

    // *****************************
    // final limit persistence and latch
    // *****************************
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            final_cnt     <= 32'h0;
            final_latched <= 1'b0;
        end else begin
            final_cnt <= (FINAL_LIMIT_TRIP_I && chain_open && !final_hold)
                         ? final_cnt + 32'h1 : 32'h0;
            if (FINAL_LIMIT_TRIP_I && chain_open && final_hold)
                final_latched <= 1'b1;
            else if (op_reset)
                final_latched <= 1'b0;
        end
    end

    // *****************************
    // door opening timeout, A and B
    // *****************************
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tmo_a  <= 32'h0;
            tmo_b  <= 32'h0;
            slip_a <= 1'b0;
            slip_b <= 1'b0;
        end else begin
            tmo_a  <= DOOR_A_OPEN_COMMAND_I && !slip_a
                      ? tmo_a + 32'h1 : 32'h0;
            tmo_b  <= DOOR_B_OPEN_COMMAND_I && !slip_b
                      ? tmo_b + 32'h1 : 32'h0;
            // hold "open" until the open command is withdrawn
            slip_a <= tmo_a_hit || (slip_a && DOOR_A_OPEN_COMMAND_I);
            slip_b <= tmo_b_hit || (slip_b && DOOR_B_OPEN_COMMAND_I);
        end
    end

    // *****************************
    // door lock recovery sequence
    // *****************************
    wire lock_fail = lock_open && CALL_PENDING_I;
    lfs_pkg::lfs_lock_t next_lock_st;
    always_comb begin
        next_lock_st = lock_st;
        unique case (lock_st)
            lfs_pkg::LFS_D_IDLE:
                if (lock_fail)
                    next_lock_st = auto_door ? lfs_pkg::LFS_D_OPEN
                                             : lfs_pkg::LFS_D_WAIT;
            lfs_pkg::LFS_D_OPEN:
                next_lock_st = lfs_pkg::LFS_D_CLOSE;
            lfs_pkg::LFS_D_CLOSE:
                if (lock_cnt >= LOCK_DELAY - 1)
                    next_lock_st = !lock_open ? lfs_pkg::LFS_D_IDLE
                                 : retry_cnt == lfs_pkg::DOOR_RETRIES
                                 ? lfs_pkg::LFS_D_DONE
                                 : lfs_pkg::LFS_D_OPEN;
            lfs_pkg::LFS_D_WAIT:
                if (!lock_fail)
                    next_lock_st = lfs_pkg::LFS_D_IDLE;
                else if (lock_cnt >= LOCK_DELAY - 1)
                    next_lock_st = lfs_pkg::LFS_D_DONE;
            lfs_pkg::LFS_D_DONE:
                if (!lock_open)
                    next_lock_st = lfs_pkg::LFS_D_IDLE;
            default: next_lock_st = lfs_pkg::LFS_D_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lock_st   <= lfs_pkg::LFS_D_IDLE;
            lock_cnt  <= 32'h0;
            retry_cnt <= 2'h0;
        end else begin
            lock_st   <= next_lock_st;
            lock_cnt  <= next_lock_st != lock_st ? 32'h0 : lock_cnt + 32'h1;
            // first reopen counts as retry one, so three reopens in all
            if (next_lock_st == lfs_pkg::LFS_D_OPEN)
                retry_cnt <= retry_cnt + 2'h1;
            else if (lock_st == lfs_pkg::LFS_D_IDLE)
                retry_cnt <= 2'h0;
        end
    end

    // *****************************
    // action outputs
    // *****************************
    wire stop_fault = final_latched || PARAM_MEM_FAULT_I;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CLEAR_ALL_CALLS_O     <= 1'b0;
            CLEAR_CAR_CALLS_O     <= 1'b0;
            BLOCK_LANDING_CALLS_O <= 1'b0;
            STOP_CAR_O            <= 1'b0;
            SAFETY_LAMP_O         <= 1'b0;
            DOOR_REOPEN_O         <= 1'b0;
            DOOR_RECLOSE_O        <= 1'b0;
            DOOR_A_OPEN_O         <= 1'b0;
            DOOR_B_OPEN_O         <= 1'b0;
        end else begin
            CLEAR_ALL_CALLS_O     <= cond[lfs_pkg::E_7]
                                     || lock_st == lfs_pkg::LFS_D_DONE;
            CLEAR_CAR_CALLS_O     <= cond[lfs_pkg::E_12];
            BLOCK_LANDING_CALLS_O <= final_latched;
            STOP_CAR_O            <= cond[lfs_pkg::E_12] || stop_fault;
            SAFETY_LAMP_O         <= !chain_open;
            DOOR_REOPEN_O         <= lock_st == lfs_pkg::LFS_D_OPEN;
            DOOR_RECLOSE_O        <= lock_st == lfs_pkg::LFS_D_CLOSE;
            DOOR_A_OPEN_O         <= DOOR_A_OPEN_LIMIT_I || slip_a;
            DOOR_B_OPEN_O         <= DOOR_B_OPEN_LIMIT_I || slip_b;
        end
    end

    // *****************************
    // assertions
    // *****************************
    a_stop_fault_7: assert property (@(posedge CLK_I) disable iff (RST_I)
        cond[lfs_pkg::E_7] |=> CLEAR_ALL_CALLS_O && !SAFETY_LAMP_O)
        else $error("fault 7 did not clear calls");
    a_lock_rise_9: assert property (@(posedge CLK_I) disable iff (RST_I)
        rise[lfs_pkg::E_9] |=> status[lfs_pkg::E_9]
            && last_fault[7:0] == lfs_pkg::F_DOOR_LOCK
               || last_fault[7:0] > lfs_pkg::F_DOOR_LOCK)
        else $error("fault 9 not recorded");
    a_lock_sub_code: assert property (@(posedge CLK_I) disable iff (RST_I)
        rise[lfs_pkg::E_9] && !LANDING_LOCKS_I && cond == rise
        |=> last_fault == {lfs_pkg::SUB_LANDING, lfs_pkg::F_DOOR_LOCK})
        else $error("fault 9 wrong sub-code");
    a_retry_bound: assert property (@(posedge CLK_I) disable iff (RST_I)
        retry_cnt <= lfs_pkg::DOOR_RETRIES)
        else $error("too many door retries");
    a_wait_done: assert property (@(posedge CLK_I) disable iff (RST_I)
        lock_st == lfs_pkg::LFS_D_DONE |=> CLEAR_ALL_CALLS_O)
        else $error("calls not cancelled after lock fault");
    a_door_a_open: assert property (@(posedge CLK_I) disable iff (RST_I)
        tmo_a_hit |=> slip_a ##1 DOOR_A_OPEN_O)
        else $error("door A timeout not treated as open");
    a_door_b_rec: assert property (@(posedge CLK_I) disable iff (RST_I)
        tmo_b_hit && !$past(tmo_b_hit) |=> status[lfs_pkg::E_11])
        else $error("fault 11 not raised");
    a_travel_stop: assert property (@(posedge CLK_I) disable iff (RST_I)
        chain_open && CAR_RUNNING_I |=> STOP_CAR_O && CLEAR_CAR_CALLS_O)
        else $error("fault 12 did not stop car");
    a_thermal_both: assert property (@(posedge CLK_I) disable iff (RST_I)
        th1_open && th2_open |-> sub_th == lfs_pkg::SUB_TH_BOTH)
        else $error("thermal sub-code wrong");
    a_final_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
        final_latched && !op_reset |=> final_latched
            && BLOCK_LANDING_CALLS_O && STOP_CAR_O)
        else $error("fault 15 latch lost");
    a_fire_raise: assert property (@(posedge CLK_I) disable iff (RST_I)
        fire_any && !cond_q[lfs_pkg::E_16] |=> status[lfs_pkg::E_16])
        else $error("fault 16 not raised");
    c_lock_retry: cover property (@(posedge CLK_I) disable iff (RST_I)
        lock_st == lfs_pkg::LFS_D_CLOSE && next_lock_st == lfs_pkg::LFS_D_DONE);
    c_final_latch: cover property (@(posedge CLK_I) disable iff (RST_I)
        rise[lfs_pkg::E_15]);
    c_final_reset: cover property (@(posedge CLK_I) disable iff (RST_I)
        final_latched && op_reset);
    c_irq: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(IRQ_O));
endmodule
`default_nettype wire

// ### bench/lfs_door_model.sv
// Purpose: door operator model driving the open limit switches
// Assumes: open commands are sampled on the rising clock edge
// Notes:   a stalled door never reaches its open limit
`timescale 1ns/1ps
`default_nettype none
module lfs_door_model (
    // clock
    input  wire logic       clk_i,
    // commands and fault injection
    input  wire logic [1:0] open_cmd_i,
    input  wire logic [1:0] stall_i,
    // limit switches, high = fully open
    output logic      [1:0] open_limit_o
);
    logic [1:0] cnt [2];
    // travel takes four cycles, limit drops with the command
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= open_cmd_i[i] ? cnt[i] + {1'b0, cnt[i] != 2'h3} : 2'h0;
            open_limit_o[i] <= open_cmd_i[i] && !stall_i[i] && cnt[i] == 2'h3;
        end
    end
endmodule
`default_nettype wire

// ### bench/test_lift_fault_supervisor.sv
// Purpose: self-checking bench for the lift fault supervisor
// Assumes: short hold and delay counts given as parameters
// Notes:   expected read values pass through a queue to a watcher
`timescale 1ns/1ps
`default_nettype none
module test_lift_fault_supervisor;
    localparam int HOLD = 20;
    localparam int DLY  = 10;
    logic        clk, rst, wr, rd, rd_seen;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic tap, trip, lck, cdr, call, run, th1, th2, tth, pmf;
    logic [3:0]  fire;
    logic [1:0]  cmd, stall, lim;
    logic ca, cc, blk, stp, lamp, reo, rec, oa, ob, irq;
    logic [31:0] exp_q[$];
    logic [10:0] tv [4] = '{11'h201, 11'h402, 11'h003, 11'h70a};
    int          n_fail = 0, cmp_count = 0, cycles = 0, n;
    lfs_supervisor #(.FINAL_HOLD(HOLD), .LOCK_DELAY(DLY)) lfs_supervisor_inst (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .SAFETY_TAP_FIRST_I(tap),
        .FINAL_LIMIT_TRIP_I(trip), .LANDING_LOCKS_I(lck), .CAR_DOOR_I(cdr),
        .CALL_PENDING_I(call), .CAR_RUNNING_I(run),
        .DOOR_A_OPEN_COMMAND_I(cmd[0]), .DOOR_A_OPEN_LIMIT_I(lim[0]),
        .DOOR_B_OPEN_COMMAND_I(cmd[1]), .DOOR_B_OPEN_LIMIT_I(lim[1]),
        .MOTOR_THERMAL_CONTACT_ONE_I(th1), .MOTOR_THERMAL_CONTACT_TWO_I(th2),
        .CAR_TOP_BOARD_THERMAL_I(tth), .PARAM_MEM_FAULT_I(pmf),
        .FIRE_SENSOR_I(fire), .CLEAR_ALL_CALLS_O(ca), .CLEAR_CAR_CALLS_O(cc),
        .BLOCK_LANDING_CALLS_O(blk), .STOP_CAR_O(stp), .SAFETY_LAMP_O(lamp),
        .DOOR_REOPEN_O(reo), .DOOR_RECLOSE_O(rec), .DOOR_A_OPEN_O(oa),
        .DOOR_B_OPEN_O(ob), .IRQ_O(irq));
    lfs_door_model lfs_door_model_inst (.clk_i(clk), .open_cmd_i(cmd),
        .stall_i(stall), .open_limit_o(lim));
    // clock and timeout
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // watcher: read data stands the cycle after the strobe
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen) cmp("rdata", exp_q.pop_front(), rdata);
    end
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic lvl(string nm, logic e, logic g);
        cmp(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic pause(int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wrr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        {wr, rd, addr, wdata, trip, call, run, tth, pmf} = '0;
        {fire, cmd, stall} = '0;
        {tap, lck, cdr, th1, th2, rst} = '1;
        void'($urandom(99768));
        pause(3);
        rst <= 1'b0;
        rdr(lfs_pkg::A_CTRL, lfs_pkg::CTRL_RST);
        rdr(8'h20, 32'h0);
        wrr(lfs_pkg::A_MASK, 32'h1ff);
        tap <= 1'b0;
        pause(3);
        lvl("clear_all", 1'b1, ca);
        lvl("lamp", 1'b0, lamp);
        lvl("irq", 1'b1, irq);
        rdr(lfs_pkg::A_LAST, 32'h07);
        run <= 1'b1;
        pause(3);
        lvl("stop", 1'b1, stp);
        lvl("clear_car", 1'b1, cc);
        rdr(lfs_pkg::A_LAST, 32'h0c);
        {tap, run} <= 2'b10;
        wrr(lfs_pkg::A_STATUS, 32'h1ff);
        pause(2);
        lvl("irq", 1'b0, irq);
        $display("test chain faults done");
        {tap, trip} <= 2'b01;
        pause(HOLD - 4);
        lvl("block", 1'b0, blk);
        pause(8);
        {tap, trip} <= 2'b10;
        pause(3);
        lvl("block", 1'b1, blk);
        lvl("stop", 1'b1, stp);
        rdr(lfs_pkg::A_LAST, 32'h0f);
        wrr(lfs_pkg::A_CTRL, 32'h1f);
        pause(3);
        lvl("block", 1'b0, blk);
        $display("test final limit done");
        foreach (tv[i]) begin
            {th1, th2, tth} <= tv[i][10:8];
            pause(3);
            rdr(lfs_pkg::A_LAST, {16'h0, tv[i][7:0], 8'h0d});
            {th1, th2, tth} <= 3'b110;
            pause(2);
        end
        pmf <= 1'b1;
        pause(3);
        lvl("stop", 1'b1, stp);
        rdr(lfs_pkg::A_LAST, 32'h0e);
        {pmf, fire} <= {1'b0, 4'($urandom_range(15, 1))};
        pause(3);
        rdr(lfs_pkg::A_LAST, 32'h10);
        fire <= 4'h0;
        $display("test sensor faults done");
        wrr(lfs_pkg::A_CTRL, 32'h1c);
        {call, lck} <= 2'b10;
        pause(3);
        lvl("clear_all", 1'b0, ca);
        rdr(lfs_pkg::A_LAST, 32'h0509);
        pause(DLY);
        lvl("clear_all", 1'b1, ca);
        {call, lck} <= 2'b01;
        wrr(lfs_pkg::A_CTRL, 32'h1e);
        {call, cdr} <= 2'b10;
        n = 0;
        repeat (90) begin
            @(posedge clk);
            n += int'(reo);
        end
        cmp("reopens", 32'h3, n);
        lvl("clear_all", 1'b1, ca);
        lvl("reclose", 1'b0, rec);
        rdr(lfs_pkg::A_LAST, 32'h0609);
        {call, cdr} <= 2'b01;
        $display("test door lock done");
        wrr(lfs_pkg::A_OPEN_TMO, 32'h8);
        for (int i = 0; i < 2; i++) begin
            {stall, cmd} <= {2'b11, 2'(i + 1)};
            pause(14);
            lvl("door_open", 1'b1, i ? ob : oa);
            rdr(lfs_pkg::A_LAST, 32'h0a + i);
            cmd <= 2'b00;
            pause(3);
        end
        wrr(lfs_pkg::A_STATUS, 32'h1ff);
        {stall, cmd} <= 4'b0011;
        pause(14);
        rdr(lfs_pkg::A_STATUS, 32'h0);
        {cmd, pmf} <= 3'b001;
        wrr(lfs_pkg::A_MASK, 32'h0);
        pause(3);
        lvl("irq", 1'b0, irq);
        $display("test door timeout and mask done");
        pause(3);
        close_out();
    end
endmodule
`default_nettype wire
